// ==== smbas_top.sv ====
// SMBus slave acknowledge generation and status vector, AXI4-Lite regs.
// Assumes open-drain SCL/SDA resolved outside; pins are asynchronous.
//
// Notes on behaviour
// - Writing ACK sets the value sent; reading while sending returns received ACK.
// - Software mode raises ack_request on every received byte.
// - ACK must be written before irq_flag clears; otherwise a NACK goes out.
// - A write to ACK shows on SDA at once; SCL stays low meanwhile.
// - A software NACKed address makes the slave deaf until next START.
// - hw_ack_enable set turns on automatic address match and acknowledge.
// - Hardware mode drives the current ACK bit on each received data byte.
// - ack_request stays clear in hardware acknowledge mode.
// - Hardware NACKed address: deaf until START, no interrupt raised.
// - Vector 0010 without ack_request reports a received slave address.
// - Vector 0010 with arbitration lost: reschedule via begin flag, expect 1110; here the master bit always reads 0, so 1110 never appears.
// - Vector 0001 reports STOP while addressed; firmware clears end flag.
// - Vector 0000 reports a received data byte; firmware sets next ACK.
// - Arbitration loss vectors 0010, 0001, 0000; abort or reschedule.
// - Arbitration lost during STOP needs no firmware response.
// - Status vector is master, direction, begin flag, end flag, high first.
// - While irq_flag is set, SCL is held low.
// - Clearing irq_flag also clears arbitration_lost.
`timescale 1ns/10ps
module smbas_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    output logic             irq
);
    smbas_pkg::smbas_ctrl_t  ctrl;
    smbas_pkg::smbas_mask_t  mask_reg;
    smbas_pkg::smbas_ev_t    ev_status;
    smbas_pkg::smbas_ev_t    ev_enable;
    smbas_pkg::smbas_state_t state;
    smbas_pkg::smbas_state_t next_state;
    logic [7:0]  own_addr;
    logic [7:0]  data_rx;
    logic [7:0]  data_tx;
    logic [7:0]  shifter;
    logic [3:0]  bit_cnt;
    logic        rd_dir;
    logic        addressed;
    logic [1:0]  scl_sync;
    logic [1:0]  sda_sync;
    logic        scl_prev;
    logic        sda_prev;
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr_q;
    logic [7:0]  w_byte_q;
    logic        w_lane_q;

    // Pin synchronisers: stage 0 is read only by stage 1
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_i};
            sda_sync <= {sda_sync[0], sda_i};
            scl_prev <= scl_sync[1];
            sda_prev <= sda_sync[1];
        end
    end

    wire scl_lvl   = scl_sync[1];
    wire sda_lvl   = sda_sync[1];
    wire scl_rise  = scl_lvl & ~scl_prev;
    wire scl_fall  = ~scl_lvl & scl_prev;
    wire start_det = scl_lvl & scl_prev & sda_prev & ~sda_lvl;
    wire stop_det  = scl_lvl & scl_prev & ~sda_prev & sda_lvl;
    wire hw        = mask_reg.hw_ack_enable;
    wire byte_end  = scl_fall & (bit_cnt == smbas_pkg::BYTE_BITS);
    wire addr_match =
        ((shifter[7:1] ^ own_addr[7:1]) & mask_reg.compare) == 7'h00;
    // Hardware mode always acknowledges a matched address
    wire ack_drv = (state == smbas_pkg::S_ADDR_ACK && hw) ? 1'b1 : ctrl.ack;

    // Register write path: address and data accepted in either order
    wire do_write = aw_held & w_held & ~bvalid;
    wire wr_en    = do_write & w_lane_q;
    wire wr_ctrl  = wr_en & (aw_addr_q == smbas_pkg::OFS_CTRL);
    wire irq_clr  = wr_ctrl & ~w_byte_q[0] & ctrl.irq_flag;
    wire wr_hit   = aw_addr_q == smbas_pkg::OFS_CTRL
                  | aw_addr_q == smbas_pkg::OFS_DATA
                  | aw_addr_q == smbas_pkg::OFS_OWN
                  | aw_addr_q == smbas_pkg::OFS_MASK
                  | aw_addr_q == smbas_pkg::OFS_ICLR
                  | aw_addr_q == smbas_pkg::OFS_IEN;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            awready   <= 1'b0;
            wready    <= 1'b0;
            aw_addr_q <= 8'h00;
            w_byte_q  <= 8'h00;
            w_lane_q  <= 1'b0;
        end else begin
            awready <= do_write | ~(aw_held | (awvalid & awready));
            wready  <= do_write | ~(w_held | (wvalid & wready));
            if (awvalid && awready) begin
                aw_held   <= 1'b1;
                aw_addr_q <= awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (wvalid && wready) begin
                w_held   <= 1'b1;
                w_byte_q <= wdata[7:0];
                w_lane_q <= wstrb[0];
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= smbas_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp  <= wr_hit ? smbas_pkg::RESP_OKAY
                             : smbas_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Read path: one outstanding read, answered the cycle after it is taken
    logic [7:0] rd_byte;
    logic       rd_hit;
    always_comb begin
        rd_byte = 8'h00;
        rd_hit  = 1'b1;
        unique case (araddr)
            smbas_pkg::OFS_CTRL:  rd_byte = ctrl;
            smbas_pkg::OFS_DATA:  rd_byte = data_rx;
            smbas_pkg::OFS_OWN:   rd_byte = own_addr;
            smbas_pkg::OFS_MASK:  rd_byte = mask_reg;
            smbas_pkg::OFS_ISTAT: rd_byte = {5'h00, ev_status};
            smbas_pkg::OFS_IEN:   rd_byte = {5'h00, ev_enable};
            smbas_pkg::OFS_ICLR:  rd_byte = 8'h00;
            default:              rd_hit  = 1'b0;
        endcase
    end

    wire rd_take = arvalid & arready;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= smbas_pkg::RESP_OKAY;
        end else begin
            arready <= ~(rd_take | (rvalid & ~rready));
            if (rd_take) begin
                rvalid <= 1'b1;
                rdata  <= {24'h00_0000, rd_byte};
                rresp  <= rd_hit ? smbas_pkg::RESP_OKAY
                                 : smbas_pkg::RESP_SLVERR;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            own_addr  <= smbas_pkg::OWN_RESET;
            mask_reg  <= smbas_pkg::MASK_RESET;
            ev_enable <= smbas_pkg::IEN_RESET;
            data_tx   <= 8'h00;
        end else if (wr_en) begin
            if (aw_addr_q == smbas_pkg::OFS_OWN)
                own_addr <= w_byte_q;
            if (aw_addr_q == smbas_pkg::OFS_MASK)
                mask_reg <= w_byte_q;
            if (aw_addr_q == smbas_pkg::OFS_IEN)
                ev_enable <= w_byte_q[2:0];
            if (aw_addr_q == smbas_pkg::OFS_DATA)
                data_tx <= w_byte_q;
        end
    end

    // Bus events decided from the current state and the line edges
    logic ev_irq;
    logic ev_ackreq;
    logic ev_arb;
    logic ev_stop;
    logic ev_ack_rx;
    always_comb begin
        next_state = state;
        ev_irq     = 1'b0;
        ev_ackreq  = 1'b0;
        ev_arb     = 1'b0;
        ev_stop    = 1'b0;
        ev_ack_rx  = 1'b0;
        if (start_det) begin
            next_state = smbas_pkg::S_ADDR;
        end else if (stop_det) begin
            next_state = smbas_pkg::S_IGNORE;
            ev_stop    = addressed;
            ev_irq     = addressed;
        end else begin
            unique case (state)
                smbas_pkg::S_ADDR, smbas_pkg::S_RX: begin
                    if (byte_end) begin
                        if (state == smbas_pkg::S_ADDR && hw && !addr_match)
                            next_state = smbas_pkg::S_IGNORE;
                        else if (state == smbas_pkg::S_ADDR)
                            next_state = smbas_pkg::S_ADDR_ACK;
                        else
                            next_state = smbas_pkg::S_RX_ACK;
                        if (!hw && next_state != smbas_pkg::S_IGNORE) begin
                            ev_irq    = 1'b1;
                            ev_ackreq = 1'b1;
                        end
                    end
                end
                smbas_pkg::S_ADDR_ACK, smbas_pkg::S_RX_ACK: begin
                    if (scl_fall) begin
                        // Hardware mode reports only after the ACK bit
                        ev_irq = hw;
                        if (!ack_drv)
                            next_state = smbas_pkg::S_IGNORE;
                        else if (state == smbas_pkg::S_ADDR_ACK && rd_dir)
                            next_state = smbas_pkg::S_TX;
                        else
                            next_state = smbas_pkg::S_RX;
                    end
                end
                smbas_pkg::S_TX: begin
                    // Released for a one but line low: a bus error as slave
                    if (scl_rise && shifter[7] && !sda_lvl) begin
                        ev_arb     = 1'b1;
                        ev_irq     = 1'b1;
                        next_state = smbas_pkg::S_IGNORE;
                    end else if (byte_end) begin
                        next_state = smbas_pkg::S_TX_ACK;
                    end
                end
                smbas_pkg::S_TX_ACK: begin
                    ev_ack_rx = scl_rise;
                    if (scl_fall) begin
                        ev_irq     = 1'b1;
                        next_state = ctrl.ack ? smbas_pkg::S_TX
                                              : smbas_pkg::S_IGNORE;
                    end
                end
                smbas_pkg::S_IGNORE: begin
                    next_state = smbas_pkg::S_IGNORE;
                end
            endcase
        end
    end

    // Transfer engine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state     <= smbas_pkg::S_IGNORE;
            bit_cnt   <= 4'h0;
            shifter   <= 8'h00;
            rd_dir    <= 1'b0;
            addressed <= 1'b0;
            data_rx   <= 8'h00;
        end else begin
            state <= next_state;
            if (next_state != state)
                bit_cnt <= 4'h0;
            else if (scl_rise)
                bit_cnt <= bit_cnt + 4'h1;
            if (next_state == smbas_pkg::S_TX && state != smbas_pkg::S_TX)
                shifter <= data_tx;
            else if (state == smbas_pkg::S_TX && bit_cnt == 4'h0
                     && ctrl.irq_flag)
                shifter <= data_tx;
            else if (scl_rise && state == smbas_pkg::S_TX)
                shifter <= {shifter[6:0], 1'b0};
            else if (scl_rise && (state == smbas_pkg::S_ADDR
                                  || state == smbas_pkg::S_RX))
                shifter <= {shifter[6:0], sda_lvl};
            if (byte_end && state == smbas_pkg::S_ADDR)
                rd_dir <= shifter[0];
            if (byte_end && state == smbas_pkg::S_RX)
                data_rx <= shifter;
            if (start_det || stop_det)
                addressed <= 1'b0;
            else if (state == smbas_pkg::S_ADDR_ACK && scl_fall && ack_drv)
                addressed <= 1'b1;
        end
    end

    // Control and status register; hardware sets win over software clears
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= smbas_pkg::CTRL_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl.begin_condition_flag <= w_byte_q[5];
                ctrl.end_condition_flag   <= w_byte_q[4];
                ctrl.ack                  <= w_byte_q[1];
                ctrl.irq_flag <= ctrl.irq_flag & w_byte_q[0];
            end
            if (irq_clr) begin
                ctrl.arbitration_lost <= 1'b0;
                ctrl.ack_request      <= 1'b0;
            end
            if (start_det)
                ctrl.begin_condition_flag <= 1'b1;
            // A STOP must read 0001 even after a transmitted byte
            if (start_det || stop_det)
                ctrl.transmit_direction <= 1'b0;
            else if (state == smbas_pkg::S_TX && scl_rise)
                ctrl.transmit_direction <= 1'b1;
            if (ev_stop)
                ctrl.end_condition_flag <= 1'b1;
            if (ev_irq)
                ctrl.irq_flag <= 1'b1;
            if (ev_arb)
                ctrl.arbitration_lost <= 1'b1;
            // Default to NACK until firmware writes the bit
            if (ev_ackreq)
                ctrl.ack <= 1'b0;
            if (ev_ack_rx)
                ctrl.ack <= ~sda_lvl;
            if (hw)
                ctrl.ack_request <= 1'b0;
            else if (ev_ackreq)
                ctrl.ack_request <= 1'b1;
            // No master engine here, so the master bit reads zero
            ctrl.master <= 1'b0;
        end
    end

    // Sticky event status, write-one-to-clear register, enabled level irq
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ev_status <= 3'h0;
            irq       <= 1'b0;
        end else begin
            if (wr_en && aw_addr_q == smbas_pkg::OFS_ICLR)
                ev_status <= ev_status & ~w_byte_q[2:0] | {ev_arb, ev_stop,
                             ev_irq & ~ev_arb & ~ev_stop};
            else
                ev_status <= ev_status | {ev_arb, ev_stop,
                             ev_irq & ~ev_arb & ~ev_stop};
            irq <= |(ev_status & ev_enable);
        end
    end

    // Line drivers; SDA only changes while SCL is low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
            scl_o  <= 1'b0;
            sda_o  <= 1'b0;
        end else begin
            scl_oe <= ctrl.irq_flag;
            if (state == smbas_pkg::S_ADDR_ACK
                || state == smbas_pkg::S_RX_ACK)
                sda_oe <= ack_drv;
            else if (state == smbas_pkg::S_TX) begin
                if (!scl_lvl && !ctrl.irq_flag
                    && bit_cnt != smbas_pkg::BYTE_BITS)
                    sda_oe <= ~shifter[7];
            end else
                sda_oe <= 1'b0;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_stall;
        ctrl.irq_flag |=> scl_oe;
    endproperty
    a_stall: assert property (p_stall)
        else $error("SCL not held while irq_flag set");

    property p_arb_clr;
        $fell(ctrl.irq_flag) |-> !ctrl.arbitration_lost;
    endproperty
    a_arb_clr: assert property (p_arb_clr)
        else $error("arbitration_lost survived irq clear");

    property p_ackreq;
        (byte_end && !hw && !start_det && !stop_det
         && (state == smbas_pkg::S_RX
             || (state == smbas_pkg::S_ADDR)))
        |=> ctrl.ack_request && ctrl.irq_flag;
    endproperty
    a_ackreq: assert property (p_ackreq)
        else $error("ack_request missing after received byte");

    property p_nack_def;
        (state == smbas_pkg::S_RX && byte_end && !hw && !stop_det
         && !start_det) |=> !ctrl.ack;
    endproperty
    a_nack_def: assert property (p_nack_def)
        else $error("ACK not defaulted to NACK");

    property p_hw_noreq;
        hw |=> !ctrl.ack_request;
    endproperty
    a_hw_noreq: assert property (p_hw_noreq)
        else $error("ack_request set in hardware mode");

    property p_ack_drive;
        (state == smbas_pkg::S_RX_ACK && ctrl.ack) |=> sda_oe;
    endproperty
    a_ack_drive: assert property (p_ack_drive)
        else $error("ACK value not on SDA");

    property p_deaf;
        (state == smbas_pkg::S_ADDR && byte_end && hw && !addr_match
         && !stop_det && !start_det)
        |=> state == smbas_pkg::S_IGNORE && !$rose(ctrl.irq_flag);
    endproperty
    a_deaf: assert property (p_deaf)
        else $error("unmatched address not ignored");

    property p_stop_vec;
        (stop_det && addressed && !start_det)
        |=> ctrl.end_condition_flag && ctrl.irq_flag;
    endproperty
    a_stop_vec: assert property (p_stop_vec)
        else $error("STOP while addressed not reported");

    property p_addr_vec;
        (state == smbas_pkg::S_ADDR_ACK && scl_fall && hw && !wr_ctrl
         && ctrl.begin_condition_flag && !ctrl.end_condition_flag
         && !ctrl.transmit_direction)
        |=> ctrl[7:4] == smbas_pkg::VEC_ADDR && !ctrl.ack_request;
    endproperty
    a_addr_vec: assert property (p_addr_vec)
        else $error("address vector not 0010");

    c_addr: cover property (state == smbas_pkg::S_ADDR_ACK && scl_fall);
    c_stop: cover property (ev_stop);
    c_arb:  cover property (ev_arb);
    c_tx:   cover property (state == smbas_pkg::S_TX_ACK && ev_ack_rx);
endmodule // smbas_top

// ==== smbas_pkg.sv ====
// Constants and types for the SMBus acknowledge and status block.
// Assumes a 32-bit AXI4-Lite bus; each register is one aligned word.
package smbas_pkg;
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_DATA    = 8'h04;
    localparam logic [7:0] OFS_OWN     = 8'h08;
    localparam logic [7:0] OFS_MASK    = 8'h0C;
    localparam logic [7:0] OFS_ISTAT   = 8'h10;
    localparam logic [7:0] OFS_ICLR    = 8'h14;
    localparam logic [7:0] OFS_IEN     = 8'h18;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [3:0] BYTE_BITS   = 4'h8;
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] OWN_RESET   = 8'h00;
    localparam logic [7:0] MASK_RESET  = 8'hFE;
    localparam logic [2:0] IEN_RESET   = 3'h0;
    localparam logic [3:0] VEC_ADDR    = 4'h2;
    localparam logic [3:0] VEC_STOP    = 4'h1;
    localparam logic [3:0] VEC_TX_BYTE = 4'h4;

    typedef struct packed {
        logic master;
        logic transmit_direction;
        logic begin_condition_flag;
        logic end_condition_flag;
        logic ack_request;
        logic arbitration_lost;
        logic ack;
        logic irq_flag;
    } smbas_ctrl_t;

    typedef struct packed {
        logic [6:0] compare;
        logic       hw_ack_enable;
    } smbas_mask_t;

    typedef struct packed {
        logic arb;
        logic stop;
        logic byte_done;
    } smbas_ev_t;

    typedef enum logic [2:0] {
        S_IGNORE, S_ADDR, S_ADDR_ACK, S_RX, S_RX_ACK, S_TX, S_TX_ACK
    } smbas_state_t;
endpackage

// ==== smbas_master_model.sv ====
// Behavioural SMBus master driving the far side of the slave block.
// Assumes the bench resolves open-drain lines with pull-ups.
`timescale 1ns/10ps
module smbas_master_model (
    input  wire logic scl_line,
    input  wire logic sda_line,
    output logic      scl_pull,
    output logic      sda_pull
);
    // Quarter of a 125 ns bit; low phase stays well over 5 clocks
    localparam real Q = 31.25;
    int hung = 0;
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end
    // Bounded wait, so a slave that never lets go cannot hang us
    task automatic rel_scl();
        int i;
        scl_pull = 1'b0;
        for (i = 0; i < 5000 && !scl_line; i++) #10;
        if (!scl_line) hung++;
    endtask
    task automatic start();
        sda_pull = 1'b0;
        #Q;
        rel_scl();
        #Q;
        sda_pull = 1'b1;
        #Q;
        scl_pull = 1'b1;
        #Q;
    endtask
    task automatic stop();
        sda_pull = 1'b1;
        #Q;
        rel_scl();
        #Q;
        sda_pull = 1'b0;
        #Q;
    endtask
    // MSB first; ack is the ninth bit as sampled, 0 meaning ACK
    task automatic send(input logic [7:0] b, output logic ack);
        int i;
        for (i = 8; i >= 0; i--) begin
            sda_pull = (i > 0) ? ~b[i-1] : 1'b0;
            #Q;
            rel_scl();
            #Q;
            if (i == 0) ack = sda_line;
            #Q;
            scl_pull = 1'b1;
            #Q;
        end
    endtask
    // Read a byte from the slave; ack_bit 1 pulls SDA low in the ninth bit
    task automatic recv(input logic ack_bit, output logic [7:0] b);
        int i;
        for (i = 8; i >= 0; i--) begin
            sda_pull = (i == 0) ? ack_bit : 1'b0;
            #Q;
            rel_scl();
            #Q;
            if (i > 0) b[i-1] = sda_line;
            #Q;
            scl_pull = 1'b1;
            #Q;
        end
    endtask
endmodule // smbas_master_model

// ==== smbus_ack_status_logic_test.sv ====
// Self-checking bench for the SMBus acknowledge and status block.
// Assumes the master model on the bus and AXI4-Lite register access.
`timescale 1ns/10ps
module smbus_ack_status_logic_test;
    logic        aclk    = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr  = 8'h00;
    logic [7:0]  araddr  = 8'h00;
    logic [31:0] wdata   = 32'h00000000;
    logic        awvalid = 1'b0;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, ak;
    logic        scl_o, scl_oe, sda_o, sda_oe, irq, m_scl, m_sda;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] rdata;
    logic [7:0]  d;
    wire         scl_i = ~(m_scl | scl_oe);
    wire         sda_i = ~(m_sda | sda_oe);
    int          err_count = 0;
    int          num_checks = 0;
    always #5 aclk = ~aclk;
    smbas_top uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
    smbas_master_model m (.scl_line(scl_i), .sda_line(sda_i),
        .scl_pull(m_scl), .sda_pull(m_sda));
    task automatic wrap_up();
        err_count = err_count + m.hung;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        int i;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (i == 50) begin err_count++; wrap_up(); end
    endtask
    task automatic rd(input logic [7:0] a);
        int i;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata[7:0];
        r = rresp;
        rready <= 1'b0;
        if (i == 50) begin err_count++; wrap_up(); end
    endtask
    // Firmware service: wait, check control bits, answer, clear
    task automatic fw(input logic [7:0] exp, msk, pre, wv);
        int i;
        for (i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge aclk);
        if (i == 3000) begin err_count++; wrap_up(); end
        rd(smbas_pkg::OFS_CTRL);
        chk(d & msk, exp);
        if (pre != 8'h00) begin
            wr(smbas_pkg::OFS_CTRL, pre);
            @(posedge aclk);
            chk({6'h00, scl_i, sda_i}, 8'h00);
            wr(smbas_pkg::OFS_IEN, 8'h00);
            @(posedge aclk);
            chk({7'h00, irq}, 8'h00);
            wr(smbas_pkg::OFS_IEN, 8'h07);
        end
        wr(smbas_pkg::OFS_ICLR, 8'h07);
        wr(smbas_pkg::OFS_CTRL, wv);
        chk({7'h00, irq}, 8'h00);
    endtask
    task automatic t_reset();
        rd(smbas_pkg::OFS_CTRL);
        chk(d, smbas_pkg::CTRL_RESET);
        rd(smbas_pkg::OFS_MASK);
        chk(d, smbas_pkg::MASK_RESET);
        rd(8'h40);
        chk({6'h00, r}, {6'h00, smbas_pkg::RESP_SLVERR});
        wr(8'h40, 8'hFF);
        chk({6'h00, bresp}, {6'h00, smbas_pkg::RESP_SLVERR});
        chk({6'h00, scl_o, sda_o}, 8'h00);
        $display("reset test done");
    endtask
    task automatic t_sw();
        wr(smbas_pkg::OFS_OWN, 8'hA0);
        wr(smbas_pkg::OFS_IEN, 8'h07);
        m.start();
        fork
            m.send(8'hA0, ak);
            fw(8'h29, 8'hF9, 8'h03, 8'h02);
        join
        chk({7'h00, ak}, 8'h00);
        fork
            m.send(8'h5A, ak);
            fw(8'h09, 8'hF9, 8'h00, 8'h02);
        join
        chk({7'h00, ak}, 8'h00);
        rd(smbas_pkg::OFS_DATA);
        chk(d, 8'h5A);
        fork
            m.stop();
            fw(8'h11, 8'hF1, 8'h00, 8'h00);
        join
        $display("software ack test done");
    endtask
    task automatic t_nack();
        m.start();
        fork
            m.send(8'hA0, ak);
            fw(8'h29, 8'hF9, 8'h00, 8'h00);
        join
        chk({7'h00, ak}, 8'h01);
        m.send(8'h5A, ak);
        chk({7'h00, ak}, 8'h01);
        rd(smbas_pkg::OFS_ISTAT);
        chk(d, 8'h00);
        m.stop();
        $display("software nack test done");
    endtask
    task automatic t_tx();
        logic [7:0] b;
        wr(smbas_pkg::OFS_DATA, 8'h96);
        m.start();
        fork
            m.send(8'hA1, ak);
            fw(8'h29, 8'hF9, 8'h00, 8'h02);
        join
        chk({7'h00, ak}, 8'h00);
        fork
            m.recv(1'b1, b);
            fw(8'h43, 8'hFF, 8'h00, 8'h02);
        join
        chk(b, 8'h96);
        fork
            m.recv(1'b0, b);
            fw(8'h41, 8'hFF, 8'h00, 8'h00);
        join
        chk(b, 8'h96);
        fork
            m.stop();
            fw(8'h11, 8'hF1, 8'h00, 8'h00);
        join
        $display("transmit test done");
    endtask
    task automatic t_hw();
        wr(smbas_pkg::OFS_MASK, 8'hFF);
        m.start();
        m.send(8'h42, ak);
        chk({7'h00, ak}, 8'h01);
        rd(smbas_pkg::OFS_ISTAT);
        chk({d[6:0], irq}, 8'h00);
        m.start();
        m.send(8'hA0, ak);
        chk({7'h00, ak}, 8'h00);
        fw(8'h21, 8'hF9, 8'h00, 8'h02);
        m.send(8'hC3, ak);
        chk({7'h00, ak}, 8'h00);
        fw(8'h01, 8'hF9, 8'h00, 8'h00);
        rd(smbas_pkg::OFS_DATA);
        chk(d, 8'hC3);
        m.send(8'h3C, ak);
        chk({7'h00, ak}, 8'h01);
        fw(8'h01, 8'hF9, 8'h00, 8'h00);
        m.stop();
        $display("hardware ack test done");
    endtask
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_sw();
        t_nack();
        t_tx();
        t_hw();
        wrap_up();
    end
    // Watchdog well above the length of the whole run
    initial begin
        #900000;
        err_count++;
        wrap_up();
    end
endmodule // smbus_ack_status_logic_test
